//--- hdl/bsr_pkg.sv
// boot status and unified ram map: shared constants and types
// assumes one clock and one active-high asynchronous reset
package bsr_pkg;

  // ==========================================================
  // unified ram
  localparam int          RAM_DEPTH      = 4608;
  localparam int          RAM_AW         = 13;
  localparam logic [15:0] RAM_LIMIT      = 16'h1200;
  localparam logic [15:0] START_PC       = 16'h0000;

  // ==========================================================
  // boot status variables (big endian words)
  localparam logic [15:0] ADDR_RESV_PTR  = 16'h11F3;
  localparam logic [15:0] ADDR_USER_BEG  = 16'h11F5;
  localparam logic [15:0] ADDR_COPY_ADDR = 16'h11FD;
  localparam logic [15:0] ADDR_RESULT    = 16'h11FF;
  localparam logic [2:0]  STAT_LAST      = 3'h6;

  // ==========================================================
  // boot result byte fields
  localparam int          RES_PIN0       = 7;
  localparam int          RES_ERR_MSB    = 4;

  // ==========================================================
  // boot control/status flags
  localparam int          FLG_TRIM_POR   = 5;
  localparam int          FLG_RUN_POR    = 4;
  localparam int          FLG_FAIL       = 2;
  localparam int          FLG_DONE       = 1;
  localparam int          FLG_RUN_SYS    = 0;
  localparam logic [7:0]  FLG_SW_MASK    = 8'h35;
  localparam logic [7:0]  FLG_RESET      = 8'h00;

  // ==========================================================
  // nvm image layout
  localparam int          NVM_AW         = 13;
  localparam logic [3:0]  FHDR_LAST      = 4'h7;
  localparam logic [3:0]  UHDR_LAST      = 4'h3;
  localparam logic [3:0]  SYNC_LAST      = 4'h2;
  localparam logic [15:0] BLANK_WORD     = 16'hFFFF;
  localparam int          PROT_USER_CONT = 0;
  localparam logic [2:0]  FERR_RANGE     = 3'h1;
  localparam logic [2:0]  FERR_NVM       = 3'h2;

  // program levels
  localparam logic [1:0]  LVL_FACTORY    = 2'h0;
  localparam logic [1:0]  LVL_USER       = 2'h1;
  localparam logic [1:0]  LVL_RUN        = 2'h2;

  typedef enum logic [8:0] {
    ST_SYNC  = 9'h001,
    ST_FHDR  = 9'h002,
    ST_FCOPY = 9'h004,
    ST_UHDR  = 9'h008,
    ST_UCOPY = 9'h010,
    ST_STAT  = 9'h020,
    ST_WAIT  = 9'h040,
    ST_RUN   = 9'h080,
    ST_NEXT  = 9'h100
  } bsr_state_t;

endpackage

//--- hdl/bsr_sync2.sv
// two flip-flop synchroniser for one level
// assumes the input is asynchronous to i_clk
`timescale 1ns/100ps
`default_nettype none
module bsr_sync2 (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      o_sync   <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- hdl/bsr_ram.sv
// unified code/data ram: one read/write port, one read-only fetch port
// assumes addresses are in range whenever the enables are high
`timescale 1ns/100ps
`default_nettype none
module bsr_ram (
  input  wire logic                       i_clk,
  input  wire logic                       i_a_en,
  input  wire logic                       i_a_we,
  input  wire logic [bsr_pkg::RAM_AW-1:0] i_a_addr,
  input  wire logic [7:0]                 i_a_wdata,
  output logic      [7:0]                 o_a_rdata,
  input  wire logic                       i_b_en,
  input  wire logic [bsr_pkg::RAM_AW-1:0] i_b_addr,
  output logic      [7:0]                 o_b_rdata
);
  logic [7:0] mem [bsr_pkg::RAM_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_a_en && i_a_we) begin
      mem[i_a_addr] <= i_a_wdata;
    end
    o_a_rdata <= (i_a_en && !i_a_we) ? mem[i_a_addr] : 8'h00;
  end

  always_ff @(posedge i_clk) begin
    o_b_rdata <= i_b_en ? mem[i_b_addr] : 8'h00;
  end
endmodule
`default_nettype wire

//--- hdl/bsr_boot_loader.sv
// boot loader: nvm copy into unified ram, boot status variables, flags
// assumes nvm answers each read with i_nvm_valid one or more clocks later, cpu halted until o_cpu_run
//
// Behaviour
// - status byte 0x00 or 0x80 means success
// - single fail bit in boot flags
// - unified ram 0x0000-0x11FF, code and data
// - run level starts cpu at 0x0000
// - copy user code/data to low ram
// - status variables written at 0x11F3-0x11FF
// - words stored big endian
// - reserved area reloaded on every reset
// - user load starts at stored nvm start
// - copy address holds the nvm address just past the last copied block
// - bit 7 holds pin 0 at boot start
// - program level register reports level
// - user level accepts appended user blocks
// - error fields bits 4:2, 1, 0
// - fail flag set when status bits 4:0 nonzero
`timescale 1ns/100ps
`default_nettype none
module bsr_boot_loader (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_pin0,
  output logic                            o_nvm_rd,
  output logic      [bsr_pkg::NVM_AW-1:0] o_nvm_addr,
  input  wire logic                       i_nvm_valid,
  input  wire logic [7:0]                 i_nvm_data,
  input  wire logic                       i_nvm_err,
  input  wire logic                       i_x_en,
  input  wire logic                       i_x_we,
  input  wire logic [15:0]                i_x_addr,
  input  wire logic [7:0]                 i_x_wdata,
  output logic      [7:0]                 o_x_rdata,
  input  wire logic                       i_c_en,
  input  wire logic [15:0]                i_c_addr,
  output logic      [7:0]                 o_c_rdata,
  input  wire logic                       i_flags_we,
  input  wire logic [7:0]                 i_flags_wdata,
  output logic      [7:0]                 o_boot_flags,
  output logic      [7:0]                 o_boot_result,
  output logic      [1:0]                 o_program_level,
  output logic      [7:0]                 o_prot_byte,
  output logic                            o_append_ok,
  output logic                            o_cpu_run,
  output logic      [15:0]                o_cpu_pc
);
  // ==========================================================
  // state
  bsr_pkg::bsr_state_t state_reg;
  logic                       rd_pend_reg;
  logic [bsr_pkg::NVM_AW-1:0] hdr_start_reg;
  logic [3:0]                 hcnt_reg;
  logic [63:0]                hdr_reg;
  logic [15:0]                cnt_reg;
  logic [15:0]                dst_reg;
  logic [15:0]                resv_ptr_reg;
  logic [15:0]                user_beg_reg;
  logic [15:0]                copy_addr_reg;
  logic [2:0]                 fact_err_reg;
  logic                       first_err_reg;
  logic                       later_err_reg;
  logic                       first_blk_reg;
  logic                       blk_bad_reg;
  logic                       pin0_reg;
  logic [2:0]                 sidx_reg;
  logic                       pin0_sync;
  wire byte_ok = rd_pend_reg && i_nvm_valid;
  wire [63:0] hdr_sh = {hdr_reg[55:0], i_nvm_data};
  wire [7:0] result = {pin0_reg, 2'b00, fact_err_reg, later_err_reg, first_err_reg};
  wire fetching = (state_reg == bsr_pkg::ST_FHDR) || (state_reg == bsr_pkg::ST_UHDR) ||
                  (((state_reg == bsr_pkg::ST_FCOPY) || (state_reg == bsr_pkg::ST_UCOPY)) &&
                   (cnt_reg != 16'h0000));
  wire trim = o_boot_flags[bsr_pkg::FLG_TRIM_POR];
  wire [16:0] blk_end = {1'b0, hdr_sh[31:16]} + {1'b0, hdr_sh[15:0]};
  bsr_sync2 u_pin0_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_pin0),
    .o_sync  (pin0_sync)
  );
  // ==========================================================
  // status variable map
  function automatic logic [15:0] stat_addr(input logic [2:0] idx);
    case (idx)
      3'h0:    stat_addr = bsr_pkg::ADDR_RESV_PTR;
      3'h1:    stat_addr = bsr_pkg::ADDR_RESV_PTR + 16'h0001;
      3'h2:    stat_addr = bsr_pkg::ADDR_USER_BEG;
      3'h3:    stat_addr = bsr_pkg::ADDR_USER_BEG + 16'h0001;
      3'h4:    stat_addr = bsr_pkg::ADDR_COPY_ADDR;
      3'h5:    stat_addr = bsr_pkg::ADDR_COPY_ADDR + 16'h0001;
      default: stat_addr = bsr_pkg::ADDR_RESULT;
    endcase
  endfunction
  function automatic logic [7:0] stat_byte(input logic [2:0] idx, input logic [15:0] rp,
                                           input logic [15:0] ub, input logic [15:0] ca,
                                           input logic [7:0] res);
    case (idx)
      3'h0:    stat_byte = rp[15:8];
      3'h1:    stat_byte = rp[7:0];
      3'h2:    stat_byte = ub[15:8];
      3'h3:    stat_byte = ub[7:0];
      3'h4:    stat_byte = ca[15:8];
      3'h5:    stat_byte = ca[7:0];
      default: stat_byte = res;
    endcase
  endfunction
  // ==========================================================
  // nvm read strobe
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_nvm_rd    <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else begin
      o_nvm_rd <= 1'b0;
      if (byte_ok) begin
        rd_pend_reg <= 1'b0;
      end else if (fetching && !rd_pend_reg) begin
        o_nvm_rd    <= 1'b1;
        rd_pend_reg <= 1'b1;
      end
    end
  end
  // ==========================================================
  // boot sequencer
  // every reset restarts the factory reload
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg       <= bsr_pkg::ST_SYNC;
      o_nvm_addr      <= '0;
      hdr_start_reg   <= '0;
      hcnt_reg        <= 4'h0;
      hdr_reg         <= 64'h0;
      cnt_reg         <= 16'h0000;
      dst_reg         <= 16'h0000;
      resv_ptr_reg    <= 16'h0000;
      user_beg_reg    <= 16'h0000;
      copy_addr_reg   <= 16'h0000;
      fact_err_reg    <= 3'h0;
      first_err_reg   <= 1'b0;
      later_err_reg   <= 1'b0;
      first_blk_reg   <= 1'b1;
      blk_bad_reg     <= 1'b0;
      pin0_reg        <= 1'b0;
      sidx_reg        <= 3'h0;
      o_program_level <= bsr_pkg::LVL_FACTORY;
      o_prot_byte     <= 8'h00;
      o_cpu_run       <= 1'b0;
      o_cpu_pc        <= bsr_pkg::START_PC;
      o_boot_result   <= 8'h00;
      o_append_ok     <= 1'b0;
    end else begin
      case (state_reg)
        bsr_pkg::ST_SYNC: begin
          hcnt_reg <= hcnt_reg + 4'h1;
          if (hcnt_reg == bsr_pkg::SYNC_LAST) begin
            pin0_reg  <= pin0_sync;
            hcnt_reg  <= 4'h0;
            state_reg <= bsr_pkg::ST_FHDR;
          end
        end
        bsr_pkg::ST_FHDR: begin
          if (byte_ok) begin
            hdr_reg    <= hdr_sh;
            hcnt_reg   <= hcnt_reg + 4'h1;
            o_nvm_addr <= o_nvm_addr + 1'b1;
            if (i_nvm_err) begin
              fact_err_reg <= bsr_pkg::FERR_NVM;
            end
            if (hcnt_reg == bsr_pkg::FHDR_LAST) begin
              o_program_level <= hdr_sh[57:56];
              o_prot_byte     <= hdr_sh[55:48];
              cnt_reg         <= hdr_sh[47:32];
              dst_reg         <= hdr_sh[31:16];
              resv_ptr_reg    <= hdr_sh[31:16];
              user_beg_reg    <= hdr_sh[15:0];
              blk_bad_reg     <= ({1'b0, hdr_sh[31:16]} + {1'b0, hdr_sh[47:32]}) >
                                 {1'b0, bsr_pkg::ADDR_RESV_PTR};
              if (({1'b0, hdr_sh[31:16]} + {1'b0, hdr_sh[47:32]}) > {1'b0, bsr_pkg::ADDR_RESV_PTR}) begin
                fact_err_reg <= bsr_pkg::FERR_RANGE;
              end
              state_reg <= bsr_pkg::ST_FCOPY;
            end
          end
        end
        bsr_pkg::ST_FCOPY: begin
          if (cnt_reg == 16'h0000) begin
            hcnt_reg      <= 4'h0;
            copy_addr_reg <= 16'(o_nvm_addr);
            if ((o_program_level == bsr_pkg::LVL_FACTORY) || trim) begin
              state_reg <= bsr_pkg::ST_STAT;
            end else begin
              // user load begins at stored start
              o_nvm_addr    <= user_beg_reg[bsr_pkg::NVM_AW-1:0];
              hdr_start_reg <= user_beg_reg[bsr_pkg::NVM_AW-1:0];
              state_reg     <= bsr_pkg::ST_UHDR;
            end
          end else if (byte_ok) begin
            cnt_reg    <= cnt_reg - 16'h0001;
            dst_reg    <= dst_reg + 16'h0001;
            o_nvm_addr <= o_nvm_addr + 1'b1;
            if (i_nvm_err) begin
              fact_err_reg <= bsr_pkg::FERR_NVM;
            end
          end
        end
        bsr_pkg::ST_UHDR: begin
          if (byte_ok) begin
            hdr_reg    <= hdr_sh;
            hcnt_reg   <= hcnt_reg + 4'h1;
            o_nvm_addr <= o_nvm_addr + 1'b1;
            if (hcnt_reg == bsr_pkg::UHDR_LAST) begin
              dst_reg <= hdr_sh[31:16];
              cnt_reg <= hdr_sh[15:0];
              // blank header ends the user chain
              if ((hdr_sh[31:16] == bsr_pkg::BLANK_WORD) || (hdr_sh[15:0] == 16'h0000)) begin
                copy_addr_reg <= 16'(hdr_start_reg);
                state_reg     <= bsr_pkg::ST_STAT;
              end else begin
                // block may not reach reserved area
                blk_bad_reg <= (blk_end > {1'b0, resv_ptr_reg}) || i_nvm_err;
                if ((blk_end > {1'b0, resv_ptr_reg}) || i_nvm_err) begin
                  first_err_reg <= first_err_reg | first_blk_reg;
                  later_err_reg <= later_err_reg | !first_blk_reg;
                end
                state_reg <= bsr_pkg::ST_UCOPY;
              end
            end
          end
        end
        bsr_pkg::ST_UCOPY: begin
          if (cnt_reg == 16'h0000) begin
            first_blk_reg <= 1'b0;
            hcnt_reg      <= 4'h0;
            hdr_start_reg <= o_nvm_addr;
            state_reg     <= bsr_pkg::ST_UHDR;
          end else if (byte_ok) begin
            cnt_reg    <= cnt_reg - 16'h0001;
            dst_reg    <= dst_reg + 16'h0001;
            o_nvm_addr <= o_nvm_addr + 1'b1;
            if (i_nvm_err) begin
              first_err_reg <= first_err_reg | first_blk_reg;
              later_err_reg <= later_err_reg | !first_blk_reg;
            end
          end
        end
        bsr_pkg::ST_STAT: begin
          sidx_reg <= sidx_reg + 3'h1;
          if (sidx_reg == bsr_pkg::STAT_LAST) begin
            o_boot_result <= result;
            o_append_ok   <= (o_program_level == bsr_pkg::LVL_USER);
            state_reg     <= bsr_pkg::ST_WAIT;
          end
        end
        bsr_pkg::ST_WAIT: begin
          // run level jumps to the bottom of ram
          if (((o_program_level == bsr_pkg::LVL_RUN) && !trim) ||
              ((o_program_level == bsr_pkg::LVL_USER) && !trim && o_prot_byte[bsr_pkg::PROT_USER_CONT]) ||
              o_boot_flags[bsr_pkg::FLG_RUN_POR] || o_boot_flags[bsr_pkg::FLG_RUN_SYS]) begin
            o_cpu_pc  <= bsr_pkg::START_PC;
            o_cpu_run <= 1'b1;
            state_reg <= bsr_pkg::ST_RUN;
          end
        end
        default: state_reg <= state_reg;
      endcase
    end
  end
  // ==========================================================
  // boot control/status flags
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_boot_flags <= bsr_pkg::FLG_RESET;
    end else begin
      if (i_flags_we) begin
        o_boot_flags <= (i_flags_wdata & bsr_pkg::FLG_SW_MASK) | (o_boot_flags & ~bsr_pkg::FLG_SW_MASK);
      end
      if ((state_reg == bsr_pkg::ST_STAT) && (sidx_reg == bsr_pkg::STAT_LAST)) begin
        o_boot_flags[bsr_pkg::FLG_DONE] <= 1'b1;
        if (|result[bsr_pkg::RES_ERR_MSB:0]) begin
          o_boot_flags[bsr_pkg::FLG_FAIL] <= 1'b1;
        end
      end
    end
  end
  // ==========================================================
  // ram port steering
  logic                       a_en;
  logic                       a_we;
  logic [15:0]                a_addr;
  logic [7:0]                 a_wdata;
  wire booting = (state_reg != bsr_pkg::ST_WAIT) && (state_reg != bsr_pkg::ST_RUN);
  always_comb begin
    a_en    = 1'b0;
    a_we    = 1'b0;
    a_addr  = dst_reg;
    a_wdata = i_nvm_data;
    if (state_reg == bsr_pkg::ST_STAT) begin
      a_en    = 1'b1;
      a_we    = 1'b1;
      a_addr  = stat_addr(sidx_reg);
      a_wdata = stat_byte(sidx_reg, resv_ptr_reg, user_beg_reg, copy_addr_reg, result);
    end else if (((state_reg == bsr_pkg::ST_FCOPY) || (state_reg == bsr_pkg::ST_UCOPY)) && byte_ok) begin
      // copied bytes land at the block target
      a_en = !blk_bad_reg && !i_nvm_err && (dst_reg < bsr_pkg::RAM_LIMIT);
      a_we = a_en;
    end else if (!booting) begin
      a_en    = i_x_en && (i_x_addr < bsr_pkg::RAM_LIMIT);
      a_we    = i_x_we;
      a_addr  = i_x_addr;
      a_wdata = i_x_wdata;
    end
  end
  // one array for code fetch and data
  bsr_ram u_ram (
    .i_clk     (i_clk),
    .i_a_en    (a_en),
    .i_a_we    (a_we),
    .i_a_addr  (a_addr[bsr_pkg::RAM_AW-1:0]),
    .i_a_wdata (a_wdata),
    .o_a_rdata (o_x_rdata),
    .i_b_en    (i_c_en && (i_c_addr < bsr_pkg::RAM_LIMIT)),
    .i_b_addr  (i_c_addr[bsr_pkg::RAM_AW-1:0]),
    .o_b_rdata (o_c_rdata)
  );
endmodule
`default_nettype wire

//--- tb/bsr_boot_loader_asserts.sv
// checker for the boot loader top ports
// assumes one clock i_clk and active-high asynchronous reset i_reset
`timescale 1ns/100ps
`default_nettype none
module bsr_boot_asserts (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        o_nvm_rd,
  input wire logic [12:0] o_nvm_addr,
  input wire logic        i_nvm_valid,
  input wire logic        i_x_en,
  input wire logic [15:0] i_x_addr,
  input wire logic [7:0]  o_x_rdata,
  input wire logic        i_c_en,
  input wire logic [15:0] i_c_addr,
  input wire logic [7:0]  o_c_rdata,
  input wire logic [7:0]  o_boot_flags,
  input wire logic [7:0]  o_boot_result,
  input wire logic [1:0]  o_program_level,
  input wire logic        o_append_ok,
  input wire logic        o_cpu_run,
  input wire logic [15:0] o_cpu_pc
);
  // ==========================================================
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic done;
  assign done = o_boot_flags[bsr_pkg::FLG_DONE];

  a_fail_from_status : assert property (
    $rose(done) |-> o_boot_flags[bsr_pkg::FLG_FAIL] == (|o_boot_result[4:0]))
    else $error("fail flag disagrees with status byte");
  a_ok_result_value : assert property (
    $rose(done) |-> ((o_boot_result == 8'h00) || (o_boot_result == 8'h80)) != o_boot_flags[bsr_pkg::FLG_FAIL])
    else $error("success encoding disagrees with fail flag");
  a_start_pc_zero : assert property (
    o_cpu_pc == 16'h0000)
    else $error("start address not zero");
  a_run_level_starts : assert property (
    $rose(done) && o_program_level == bsr_pkg::LVL_RUN && !o_boot_flags[bsr_pkg::FLG_TRIM_POR]
    |-> ##[0:2] o_cpu_run)
    else $error("run level part did not start");
  a_single_nvm_read : assert property (
    o_nvm_rd |=> !o_nvm_rd)
    else $error("second nvm read while one outstanding");
  a_nvm_addr_held : assert property (
    o_nvm_rd |=> $stable(o_nvm_addr))
    else $error("nvm address moved before answer");
  a_append_user_only : assert property (
    o_append_ok |-> o_program_level == bsr_pkg::LVL_USER && done)
    else $error("append allowed outside user level");
  a_data_unmapped : assert property (
    i_x_en && i_x_addr >= bsr_pkg::RAM_LIMIT |=> o_x_rdata == 8'h00)
    else $error("data read above ram not zero");
  a_code_unmapped : assert property (
    i_c_en && i_c_addr >= bsr_pkg::RAM_LIMIT |=> o_c_rdata == 8'h00)
    else $error("code fetch above ram not zero");
  a_boot_reads_zero : assert property (
    i_x_en && !done |=> o_x_rdata == 8'h00)
    else $error("data port answered during boot");

  c_boot_ok   : cover property ($rose(done) && !o_boot_flags[bsr_pkg::FLG_FAIL]);
  c_boot_fail : cover property ($rose(done) && o_boot_flags[bsr_pkg::FLG_FAIL]);
  c_append    : cover property ($rose(o_append_ok));
endmodule

bind bsr_boot_loader bsr_boot_asserts u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .o_nvm_rd(o_nvm_rd), .o_nvm_addr(o_nvm_addr),
  .i_nvm_valid(i_nvm_valid), .i_x_en(i_x_en), .i_x_addr(i_x_addr), .o_x_rdata(o_x_rdata),
  .i_c_en(i_c_en), .i_c_addr(i_c_addr), .o_c_rdata(o_c_rdata), .o_boot_flags(o_boot_flags),
  .o_boot_result(o_boot_result), .o_program_level(o_program_level), .o_append_ok(o_append_ok),
  .o_cpu_run(o_cpu_run), .o_cpu_pc(o_cpu_pc));
`default_nettype wire

//--- tb/bsr_nvm_model.sv
// nvm partner: one read at a time, answer after lat cycles
// assumes the bench fills mem, lat and err_addr before reset release
`timescale 1ns/100ps
`default_nettype none
module bsr_nvm_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_rd,
  input  wire logic [12:0] i_addr,
  output logic             o_valid,
  output logic      [7:0]  o_data,
  output logic             o_err
);
  logic [7:0]  mem [0:8191];
  int          lat = 1;
  int          cnt;
  logic [12:0] err_addr = 13'h1FFF;
  logic [12:0] addr_reg;
  logic        busy;
  // ==========================================================
  // read answer, data toggles while not valid
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy    <= 1'b0;
      o_valid <= 1'b0;
      o_err   <= 1'b0;
      o_data  <= 8'h00;
    end else begin
      o_valid <= 1'b0;
      o_err   <= 1'b0;
      o_data  <= ~o_data;
      if (i_rd) begin
        busy     <= 1'b1;
        addr_reg <= i_addr;
        cnt      <= 1;
      end else if (busy && cnt >= lat) begin
        busy    <= 1'b0;
        o_valid <= 1'b1;
        o_data  <= mem[addr_reg];
        o_err   <= (addr_reg == err_addr);
      end else if (busy) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/bsr_boot_loader_tb.sv
// self-checking bench for the boot loader
// assumes the nvm partner model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module bsr_boot_loader_tb;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_pin0 = 1'b0;
  logic        i_x_en = 1'b0;
  logic        i_x_we = 1'b0;
  logic [15:0] i_x_addr = 16'h0000;
  logic [7:0]  i_x_wdata = 8'h00;
  logic        i_c_en = 1'b0;
  logic [15:0] i_c_addr = 16'h0000;
  logic        i_flags_we = 1'b0;
  logic [7:0]  i_flags_wdata = 8'h00;
  logic        o_nvm_rd, i_nvm_valid, i_nvm_err, o_append_ok, o_cpu_run;
  logic [12:0] o_nvm_addr;
  logic [7:0]  i_nvm_data, o_x_rdata, o_c_rdata, o_boot_flags, o_boot_result, o_prot_byte;
  logic [1:0]  o_program_level;
  logic [15:0] o_cpu_pc;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  localparam logic [7:0] IMG [0:28] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h11, 8'hE0, 8'h00, 8'h10, 8'hA5,
    8'h5A, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h11, 8'h22, 8'h33,
    8'h11, 8'hDF, 8'h00, 8'h02, 8'hAA, 8'hBB};

  always #10 i_clk = ~i_clk;

  bsr_nvm_model u_nvm (.i_clk(i_clk), .i_reset(i_reset), .i_rd(o_nvm_rd), .i_addr(o_nvm_addr),
    .o_valid(i_nvm_valid), .o_data(i_nvm_data), .o_err(i_nvm_err));

  bsr_boot_loader u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_pin0(i_pin0), .o_nvm_rd(o_nvm_rd),
    .o_nvm_addr(o_nvm_addr), .i_nvm_valid(i_nvm_valid), .i_nvm_data(i_nvm_data), .i_nvm_err(i_nvm_err),
    .i_x_en(i_x_en), .i_x_we(i_x_we), .i_x_addr(i_x_addr), .i_x_wdata(i_x_wdata), .o_x_rdata(o_x_rdata),
    .i_c_en(i_c_en), .i_c_addr(i_c_addr), .o_c_rdata(o_c_rdata), .i_flags_we(i_flags_we),
    .i_flags_wdata(i_flags_wdata), .o_boot_flags(o_boot_flags), .o_boot_result(o_boot_result),
    .o_program_level(o_program_level), .o_prot_byte(o_prot_byte), .o_append_ok(o_append_ok),
    .o_cpu_run(o_cpu_run), .o_cpu_pc(o_cpu_pc));

  // ==========================================================
  // shared tasks
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask

  task automatic rd(input logic code, input logic [15:0] a, output logic [7:0] d);
    tick;
    i_c_en = code;
    i_x_en = !code;
    i_c_addr = a;
    i_x_addr = a;
    tick;
    i_c_en = 1'b0;
    i_x_en = 1'b0;
    d = code ? o_c_rdata : o_x_rdata;
  endtask

  task automatic word(input logic [15:0] a, input logic [15:0] exp);
    logic [7:0] h;
    logic [7:0] l;
    rd(1'b0, a, h);
    rd(1'b0, a + 16'h0001, l);
    check({h, l}, exp);
  endtask

  task automatic boot(input logic [7:0] lvl, input logic pin, input int lat, input logic [12:0] ea,
                      input logic bad);
    int n;
    logic [7:0] d;
    // user blocks kept below the reserved area unless bad adds one reaching into it
    for (n = 0; n < 8192; n++) u_nvm.mem[n] = (n < (bad ? 29 : 23)) ? IMG[n] : 8'hFF;
    u_nvm.mem[0] = lvl;
    u_nvm.lat = lat;
    u_nvm.err_addr = ea;
    i_pin0 = pin;
    i_reset = 1'b1;
    repeat (4) tick;
    i_reset = 1'b0;
    rd(1'b0, 16'h0000, d);
    check(d, 16'h0000);
    n = 0;
    while (o_boot_flags[bsr_pkg::FLG_DONE] !== 1'b1 && n < 3000) begin
      tick;
      n++;
    end
    repeat (2) tick;
    check(o_boot_flags[bsr_pkg::FLG_DONE], 16'h0001);
  endtask

  // ==========================================================
  // scenarios
  task automatic run_boot_ok;
    logic [7:0] d;
    int i;
    boot(8'h02, 1'b1, 1, 13'h1FFF, 1'b0);
    check(o_boot_result, 16'h0080);
    check(o_boot_flags[bsr_pkg::FLG_FAIL], 16'h0000);
    check(o_program_level, bsr_pkg::LVL_RUN);
    check(o_cpu_run, 16'h0001);
    check(o_append_ok, 16'h0000);
    word(16'h11F3, 16'h11E0);
    word(16'h11F5, 16'h0010);
    word(16'h11FD, 16'h0017);
    rd(1'b0, 16'h11FF, d);
    check(d, 16'h0080);
    word(16'h11E0, 16'hA55A);
    for (i = 0; i < 3; i++) begin
      rd(1'b1, i[15:0], d);
      check(d, 16'(8'h11 * (i + 1)));
    end
    rd(1'b0, 16'h1200, d);
    check(d, 16'h0000);
    rd(1'b1, 16'h1200, d);
    check(d, 16'h0000);
  endtask

  task automatic user_bad_block;
    logic [7:0] d;
    boot(8'h01, 1'b0, 3, 13'h1FFF, 1'b1);
    check(o_boot_result, 16'h0002);
    check(o_boot_flags[bsr_pkg::FLG_FAIL], 16'h0001);
    check(o_program_level, bsr_pkg::LVL_USER);
    check(o_append_ok, 16'h0001);
    word(16'h11FD, 16'h001D);
    word(16'h11E0, 16'hA55A);
    check(o_cpu_run, 16'h0000);
    // software data kept below the reserved area
    tick;
    i_x_en = 1'b1;
    i_x_we = 1'b1;
    i_x_addr = 16'h0100;
    i_x_wdata = 8'h3C;
    tick;
    i_x_en = 1'b0;
    i_x_we = 1'b0;
    rd(1'b1, 16'h0100, d);
    check(d, 16'h003C);
    i_flags_we = 1'b1;
    i_flags_wdata = 8'hD0;
    tick;
    i_flags_we = 1'b0;
    repeat (2) tick;
    check(o_boot_flags[7:6], 16'h0000);
    check(o_boot_flags[bsr_pkg::FLG_RUN_POR], 16'h0001);
    check(o_cpu_run, 16'h0001);
  endtask

  task automatic factory_nvm_err;
    boot(8'h00, 1'b0, 2, 13'h0008, 1'b0);
    check(o_boot_result, 16'h0008);
    check(o_boot_flags[bsr_pkg::FLG_FAIL], 16'h0001);
    check(o_program_level, bsr_pkg::LVL_FACTORY);
    word(16'h11FD, 16'h000A);
    check(o_cpu_run, 16'h0000);
  endtask

  // ==========================================================
  // run control
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      give_verdict;
    end
  end

  initial begin
    repeat (4) tick;
    run_boot_ok;
    user_bad_block;
    factory_nvm_err;
    give_verdict;
  end
endmodule
`default_nettype wire
